// [logic/urs_pkg.sv]
// shared constants and types for the receive status block
package urs_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BAUD    = 8'h08;
  localparam logic [7:0] OFS_RXDATA  = 8'h0c;
  localparam logic [7:0] OFS_INTSTAT = 8'h10;
  localparam logic [7:0] OFS_INTMASK = 8'h14;

  // serial_status_control field positions
  localparam int BIT_ADDR_EN  = 5;
  localparam int BIT_RX_IDLE  = 4;
  localparam int BIT_PARITY_ERROR_FLAG     = 3;
  localparam int BIT_FRAMING_ERROR_FLAG     = 2;
  localparam int BIT_OVERRUN  = 1;
  localparam int BIT_RX_AVAIL = 0;

  // control register field positions
  localparam int BIT_RX_ENABLE = 0;
  localparam int BIT_NINE_BIT  = 1;
  localparam int POS_PARITY    = 2;

  // interrupt status / mask field positions
  localparam int INT_CHAR    = 0;
  localparam int INT_OVERRUN = 1;
  localparam int INT_PARITY_ERROR_FLAG    = 2;
  localparam int INT_FRAMING_ERROR_FLAG    = 3;
  localparam int INT_ADDR    = 4;
  localparam int INT_WIDTH   = 5;

  // values after reset, and the parity mode codes
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0010;
  localparam logic [1:0]  PARITY_NONE    = 2'h0;
  localparam logic [1:0]  PARITY_EVEN    = 2'h1;
  localparam logic [1:0]  PARITY_ODD     = 2'h2;

  // receive fifo shape
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW    = 2;

  // data bit counts per character
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;

  // one received character with its error marks
  typedef struct packed {
    logic       parityErr;
    logic       framingErr;
    logic [8:0] data;
  } urs_char_t;

  // receiver states
  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } urs_rx_state_t;

endpackage

// [logic/urs_sync2.sv]
// two-flop synchroniser for the receive pin
`timescale 1ns/10ps
module urs_sync2
  import urs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // asynchronous in, synchronous out
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1;

  // idle line is high, so both stages reset high
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stage1  <= 1'b1;
      syncOut <= 1'b1;
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // urs_sync2

// [logic/urs_rx_fifo.sv]
// receive character fifo with flush
`timescale 1ns/10ps
module urs_rx_fifo
  import urs_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      resetn,
  // write side
  input  wire logic      push,
  input  wire urs_char_t pushData,
  output logic           full,
  // read side
  input  wire logic      pop,
  output urs_char_t      head,
  output logic           valid,
  // empties all entries
  input  wire logic      flush
);

  urs_char_t            mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0]   wrPtr;
  logic [FIFO_AW-1:0]   rdPtr;
  logic [FIFO_AW:0]     count;
  logic [FIFO_AW-1:0]   next_wrPtr;
  logic [FIFO_AW-1:0]   next_rdPtr;
  logic [FIFO_AW:0]     next_count;
  logic                 doPush;
  logic                 doPop;

  // compare at the counter's own width so the depth is not cut to zero
  assign full  = (count == (FIFO_AW+1)'(FIFO_DEPTH));
  assign valid = (count != '0);
  assign head  = mem[rdPtr];

  // pointer and count update; a flush beats push and pop
  always_comb
  begin
    doPush     = push && !full;
    doPop      = pop && valid;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (flush)
    begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end
    else
    begin
      if (doPush)
        next_wrPtr = wrPtr + 1'b1;
      if (doPop)
        next_rdPtr = rdPtr + 1'b1;
      if (doPush && !doPop)
        next_count = count + 1'b1;
      else if (doPop && !doPush)
        next_count = count - 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk)
  begin
    if (doPush && !flush)
      mem[wrPtr] <= pushData;
  end

endmodule // urs_rx_fifo

// [logic/urs_rx_status.sv]
// receive path, status flags and apb registers of the serial port
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module urs_rx_status
  import urs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial receive pin
  input  wire logic        rxPin,
  // interrupt
  output logic             irq
);

  logic                 rxIn;
  // software settings
  logic                 addrDetectEnable;
  logic                 rxEnable;
  logic                 nineBit;
  logic [1:0]           parityMode;
  logic [15:0]          baudDiv;
  logic [INT_WIDTH-1:0] intMask;
  logic                 next_addrDetectEnable;
  logic                 next_rxEnable;
  logic                 next_nineBit;
  logic [1:0]           next_parityMode;
  logic [15:0]          next_baudDiv;
  logic [INT_WIDTH-1:0] next_intMask;
  // hardware flags
  logic                 overrunErrorFlag;
  logic [INT_WIDTH-1:0] intStat;
  logic                 next_overrunErrorFlag;
  logic [INT_WIDTH-1:0] next_intStat;
  logic                 next_irq;
  // bus
  logic                 next_pready;
  logic                 next_pslverr;
  logic [31:0]          next_prdata;
  logic                 busDone;
  logic                 busWrite;
  logic                 busRead;
  logic                 mapped;
  // receiver
  urs_rx_state_t        rxState;
  urs_rx_state_t        next_rxState;
  logic [15:0]          tickCnt;
  logic [15:0]          next_tickCnt;
  logic [3:0]           bitCnt;
  logic [3:0]           next_bitCnt;
  logic [8:0]           rxShiftRegister;
  logic [8:0]           next_rxShiftRegister;
  logic                 parityBit;
  logic                 next_parityBit;
  logic                 charDone;
  logic [3:0]           dataBits;
  // character handling
  urs_char_t            newChar;
  urs_char_t            fifoHead;
  logic                 fifoFull;
  logic                 rxDataAvailable;
  logic                 addrActive;
  logic                 charKeep;
  logic                 pushChar;
  logic                 overrunEvt;
  logic                 clearOverrun;
  logic                 popChar;
  logic [INT_WIDTH-1:0] events;
  logic [15:0]          statusWord;

  // pin synchroniser
  urs_sync2 u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (rxPin),
    .syncOut (rxIn)
  );

  // receive fifo
  urs_rx_fifo u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .push     (pushChar),
    .pushData (newChar),
    .full     (fifoFull),
    .pop      (popChar),
    .head     (fifoHead),
    .valid    (rxDataAvailable),
    .flush    (clearOverrun)
  );

  // bus phase decode; effects land on the edge that completes the access
  assign busDone  = psel && penable && pready;
  assign busWrite = busDone && pwrite;
  assign busRead  = busDone && !pwrite;
  assign mapped   = (paddr == OFS_STATUS) || (paddr == OFS_CONTROL) ||
                    (paddr == OFS_BAUD) || (paddr == OFS_RXDATA) ||
                    (paddr == OFS_INTSTAT) || (paddr == OFS_INTMASK);

  // address mode only with nine-bit characters
  assign addrActive = addrDetectEnable && nineBit;
  assign dataBits   = nineBit ? BITS_NINE : BITS_EIGHT;

  // receiver sequencing, sampling at mid-bit
  always_comb
  begin
    next_rxState         = rxState;
    next_tickCnt         = tickCnt;
    next_bitCnt          = bitCnt;
    next_rxShiftRegister = rxShiftRegister;
    next_parityBit       = parityBit;
    charDone             = 1'b0;
    case (rxState)
      RX_IDLE:
      begin
        if (rxEnable && !rxIn)
        begin
          next_rxState = RX_START;
          next_tickCnt = {1'b0, baudDiv[15:1]};
        end
      end
      RX_START:
      begin
        if (tickCnt == 16'h0000)
        begin
          next_rxState = rxIn ? RX_IDLE : RX_DATA;
          next_tickCnt = baudDiv - 16'h0001;
          next_bitCnt  = 4'h0;
        end
        else
          next_tickCnt = tickCnt - 16'h0001;
      end
      RX_DATA:
      begin
        if (tickCnt == 16'h0000)
        begin
          next_rxShiftRegister = {rxIn, rxShiftRegister[8:1]};
          next_bitCnt          = bitCnt + 4'h1;
          next_tickCnt         = baudDiv - 16'h0001;
          if (bitCnt == dataBits - 4'h1)
            next_rxState = (!nineBit && parityMode != PARITY_NONE) ? RX_PARITY : RX_STOP;
        end
        else
          next_tickCnt = tickCnt - 16'h0001;
      end
      RX_PARITY:
      begin
        if (tickCnt == 16'h0000)
        begin
          next_parityBit = rxIn;
          next_rxState   = RX_STOP;
          next_tickCnt   = baudDiv - 16'h0001;
        end
        else
          next_tickCnt = tickCnt - 16'h0001;
      end
      RX_STOP:
      begin
        if (tickCnt == 16'h0000)
        begin
          charDone     = 1'b1;
          next_rxState = RX_IDLE;
        end
        else
          next_tickCnt = tickCnt - 16'h0001;
      end
      default:
        next_rxState = RX_IDLE;
    endcase
    // overrun clear also empties the shift register
    if (clearOverrun)
    begin
      next_rxState         = RX_IDLE;
      next_bitCnt          = 4'h0;
      next_rxShiftRegister = 9'h000;
    end
  end

  // receiver registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rxState         <= RX_IDLE;
      tickCnt         <= 16'h0000;
      bitCnt          <= 4'h0;
      rxShiftRegister <= 9'h000;
      parityBit       <= 1'b0;
    end
    else
    begin
      rxState         <= next_rxState;
      tickCnt         <= next_tickCnt;
      bitCnt          <= next_bitCnt;
      rxShiftRegister <= next_rxShiftRegister;
      parityBit       <= next_parityBit;
    end
  end

  // assemble the finished character and its error marks
  always_comb
  begin
    newChar.data       = nineBit ? rxShiftRegister : {1'b0, rxShiftRegister[8:1]};
    newChar.framingErr = !rxIn;                       // stop bit sampled low
    case (parityMode)
      PARITY_EVEN: newChar.parityErr = !nineBit && (^{newChar.data, parityBit});
      PARITY_ODD:  newChar.parityErr = !nineBit && !(^{newChar.data, parityBit});
      default:     newChar.parityErr = 1'b0;
    endcase
  end

  // address mode keeps only characters whose bit 8 is one
  // nothing is kept while overrun stands
  assign charKeep   = charDone && !overrunErrorFlag && (!addrActive || newChar.data[8]);
  assign pushChar   = charKeep && !fifoFull;
  assign overrunEvt = charKeep && fifoFull;
  assign popChar    = busRead && (paddr == OFS_RXDATA);

  // a one-to-zero write on a set flag flushes; a same-cycle overflow keeps it set
  assign clearOverrun = busWrite && (paddr == OFS_STATUS) && !pwdata[BIT_OVERRUN] &&
                        overrunErrorFlag && !overrunEvt;

  // events that feed the sticky interrupt status
  always_comb
  begin
    events              = '0;
    events[INT_CHAR]    = pushChar;
    events[INT_OVERRUN] = overrunEvt;
    events[INT_PARITY_ERROR_FLAG]    = pushChar && newChar.parityErr;
    events[INT_FRAMING_ERROR_FLAG]    = pushChar && newChar.framingErr;
    events[INT_ADDR]    = pushChar && addrActive;
  end

  // status word as software sees it
  always_comb
  begin
    statusWord               = 16'h0000;
    statusWord[BIT_ADDR_EN]  = addrDetectEnable;
    // idle reads one outside a character
    statusWord[BIT_RX_IDLE]  = (rxState == RX_IDLE);
    statusWord[BIT_PARITY_ERROR_FLAG]     = rxDataAvailable && fifoHead.parityErr;
    statusWord[BIT_FRAMING_ERROR_FLAG]     = rxDataAvailable && fifoHead.framingErr;
    statusWord[BIT_OVERRUN]  = overrunErrorFlag;
    // data available while the fifo is not empty
    statusWord[BIT_RX_AVAIL] = rxDataAvailable;
  end

  // software settings, flags and interrupt next values
  always_comb
  begin
    next_addrDetectEnable = addrDetectEnable;
    next_rxEnable         = rxEnable;
    next_nineBit          = nineBit;
    next_parityMode       = parityMode;
    next_baudDiv          = baudDiv;
    next_intMask          = intMask;
    if (busWrite)
    begin
      case (paddr)
        OFS_STATUS:  next_addrDetectEnable = pwdata[BIT_ADDR_EN];
        OFS_CONTROL:
        begin
          next_rxEnable   = pwdata[BIT_RX_ENABLE];
          next_nineBit    = pwdata[BIT_NINE_BIT];
          next_parityMode = pwdata[POS_PARITY +: 2];
        end
        OFS_BAUD:    next_baudDiv = pwdata[15:0];
        OFS_INTMASK: next_intMask = pwdata[INT_WIDTH-1:0];
        default:     next_intMask = intMask;
      endcase
    end
    // hardware sets, a write of one does nothing, a write of zero clears
    if (overrunEvt)
      next_overrunErrorFlag = 1'b1;
    else if (clearOverrun)
      next_overrunErrorFlag = 1'b0;
    else
      next_overrunErrorFlag = overrunErrorFlag;
    // read clears, a new event in the same cycle survives
    if (busRead && (paddr == OFS_INTSTAT))
      next_intStat = events;
    else
      next_intStat = intStat | events;
    next_irq = |(next_intStat & next_intMask);
  end

  // apb answer: ready one cycle into the access phase
  always_comb
  begin
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && !mapped;
    next_prdata  = 32'h00000000;
    if (next_pready && !pwrite)
    begin
      case (paddr)
        OFS_STATUS:  next_prdata = {16'h0000, statusWord};
        OFS_CONTROL: next_prdata = {28'h0000000, parityMode, nineBit, rxEnable};
        OFS_BAUD:    next_prdata = {16'h0000, baudDiv};
        OFS_RXDATA:  next_prdata = rxDataAvailable ? {23'h000000, fifoHead.data} : 32'h0;
        OFS_INTSTAT: next_prdata = {27'h0000000, intStat};
        OFS_INTMASK: next_prdata = {27'h0000000, intMask};
        default:     next_prdata = 32'h00000000;
      endcase
    end
  end

  // register bank
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      addrDetectEnable <= 1'b0;
      rxEnable         <= 1'b0;
      nineBit          <= 1'b0;
      parityMode       <= PARITY_NONE;
      baudDiv          <= BAUD_DIV_RESET;
      intMask          <= '0;
      overrunErrorFlag <= 1'b0;
      intStat          <= '0;
      irq              <= 1'b0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      prdata           <= 32'h00000000;
    end
    else
    begin
      addrDetectEnable <= next_addrDetectEnable;
      rxEnable         <= next_rxEnable;
      nineBit          <= next_nineBit;
      parityMode       <= next_parityMode;
      baudDiv          <= next_baudDiv;
      intMask          <= next_intMask;
      overrunErrorFlag <= next_overrunErrorFlag;
      intStat          <= next_intStat;
      irq              <= next_irq;
      pready           <= next_pready;
      pslverr          <= next_pslverr;
      prdata           <= next_prdata;
    end
  end

endmodule // urs_rx_status

// [tb/urs_tx_model.sv]
// remote serial transmitter driving the receive line
`timescale 1ns/10ps
module urs_tx_model
  import urs_pkg::*;
#(
  parameter int BAUD = 8
)
(
  // clock
  input  wire logic clk,
  // serial line, idle high
  output logic      rxLine
);
  initial rxLine = 1'b1;

  // hold one line level for a number of clocks
  task automatic put(input logic b, input int n);
    rxLine <= b;
    repeat (n) @(posedge clk);
  endtask

  // one frame: start, data lsb first, optional parity, stop
  task automatic send(input logic [8:0] d, input logic nine, input logic [1:0] par,
                      input logic badPar, input logic badStop);
    logic p;
    p = (par == PARITY_ODD) ? ~^d[7:0] : ^d[7:0];
    @(posedge clk);
    put(1'b0, BAUD);
    for (int i = 0; i < (nine ? 9 : 8); i++)
      put(d[i], BAUD);
    if (!nine && par != PARITY_NONE)
      put(p ^ badPar, BAUD);
    // a bad stop bit is low only past the sample point, then idles high
    if (badStop)
      put(1'b0, BAUD / 2 + 3);
    put(1'b1, BAUD + 2);
  endtask
endmodule // urs_tx_model

// [tb/urs_rx_status_assertions.sv]
// port level checks of the receive status block
`timescale 1ns/10ps
module urs_rx_status_assertions
  import urs_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial and interrupt
  input wire logic        rxPin,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic       stRd;
  logic       stWr;
  logic [7:0] hiCnt;
  logic       lastOv;
  logic       clrSeen;
  logic [7:0] next_hiCnt;
  logic       next_lastOv;
  logic       next_clrSeen;

  assign stRd = pready && !pwrite && paddr == OFS_STATUS;
  assign stWr = pready && pwrite && paddr == OFS_STATUS;

  // idle line run length and last overrun seen by software
  always_comb
  begin
    next_hiCnt   = !rxPin ? 8'h00 : (hiCnt == 8'hff ? hiCnt : hiCnt + 8'h01);
    next_lastOv  = stRd ? prdata[BIT_OVERRUN] : lastOv;
    next_clrSeen = stRd ? 1'b0 : ((stWr && !pwdata[BIT_OVERRUN]) ? 1'b1 : clrSeen);
  end

  // helper registers
  always_ff @(posedge clk)
  begin
    hiCnt   <= !resetn ? 8'h00 : next_hiCnt;
    lastOv  <= !resetn ? 1'b0 : next_lastOv;
    clrSeen <= !resetn ? 1'b0 : next_clrSeen;
  end

  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_TIME: assert property (psel && $rose(penable) |=> pready)
    else $error("ready not one cycle after access phase");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero when idle");
  AST_ERR_PAIR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  AST_STATUS_UPPER: assert property (stRd |-> prdata[31:6] == 26'h0)
    else $error("status upper bits not zero");
  // idle after a long high line
  AST_IDLE_FLAG: assert property (stRd && hiCnt == 8'hff |-> prdata[BIT_RX_IDLE])
    else $error("receiver not idle on a quiet line");
  // error flags follow the fifo head
  AST_ERR_EMPTY: assert property (stRd && !prdata[BIT_RX_AVAIL] |-> prdata[3:2] == 2'h0)
    else $error("error flag with empty buffer");
  AST_OVR_STICKY: assert property (stRd && lastOv && !clrSeen |-> prdata[BIT_OVERRUN])
    else $error("overrun cleared without software");
  AST_IRQ_RESET: assert property (pready && !pwrite && paddr == OFS_INTMASK
                                  && prdata == 32'h0 |=> !irq)
    else $error("interrupt with mask zero");
endmodule // urs_rx_status_assertions

// [tb/urs_rx_status_tb.sv]
// self-checking bench of the receive status block
`timescale 1ns/10ps
module urs_rx_status_tb;
  import urs_pkg::*;

  localparam int BAUD = 8;

  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxPin;
  logic        irq;
  logic [31:0] rdv;
  logic        err;
  int          fail_count;
  int          comparisons;

  urs_rx_status dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxPin(rxPin), .irq(irq));
  urs_tx_model #(.BAUD(BAUD)) tx (.clk(clk), .rxLine(rxPin));

  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // value compare
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, waits for ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    err = pslverr;
    if (n >= 50) check_eq(32'h0, 32'h1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_eq(rdv, exp);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    fail_count = 0; comparisons = 0;
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_STATUS, 32'h10);
    rd(OFS_CONTROL, 32'h0);
    rd(OFS_BAUD, 32'h10);
    rd(OFS_INTMASK, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check_eq({31'h0, err}, 32'h1);
    done("reset");
    wr(OFS_BAUD, BAUD);
    wr(OFS_CONTROL, 32'h5);
    tx.send(9'h0a5, 1'b0, PARITY_EVEN, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h11);
    check_eq({31'h0, irq}, 32'h0);
    wr(OFS_INTMASK, 32'h1);
    repeat (2) @(posedge clk);
    check_eq({31'h0, irq}, 32'h1);
    rd(OFS_INTSTAT, 32'h1);
    repeat (2) @(posedge clk);
    check_eq({31'h0, irq}, 32'h0);
    rd(OFS_RXDATA, 32'h0a5);
    rd(OFS_STATUS, 32'h10);
    done("interrupt");
    fork
      tx.send(9'h03c, 1'b0, PARITY_EVEN, 1'b0, 1'b0);
      begin
        repeat (40) @(posedge clk);
        rd(OFS_STATUS, 32'h00);
      end
    join
    rd(OFS_RXDATA, 32'h03c);
    done("busy");
    tx.send(9'h011, 1'b0, PARITY_EVEN, 1'b1, 1'b0);
    tx.send(9'h022, 1'b0, PARITY_EVEN, 1'b0, 1'b1);
    rd(OFS_STATUS, 32'h19);
    rd(OFS_RXDATA, 32'h011);
    rd(OFS_STATUS, 32'h15);
    rd(OFS_RXDATA, 32'h022);
    rd(OFS_STATUS, 32'h10);
    done("errors");
    wr(OFS_STATUS, 32'h02);
    // long quiet line so the idle check of the checker is reached
    repeat (260) @(posedge clk);
    rd(OFS_STATUS, 32'h10);
    for (int i = 0; i < 6; i++)
      tx.send(9'h040 + 9'(i), 1'b0, PARITY_EVEN, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h13);
    rd(OFS_RXDATA, 32'h040);
    wr(OFS_STATUS, 32'h02);
    rd(OFS_STATUS, 32'h13);
    wr(OFS_STATUS, 32'h00);
    rd(OFS_STATUS, 32'h10);
    tx.send(9'h077, 1'b0, PARITY_EVEN, 1'b0, 1'b0);
    rd(OFS_RXDATA, 32'h077);
    // overflow again, free one slot, then a new character must be dropped
    for (int i = 0; i < 5; i++)
      tx.send(9'h050 + 9'(i), 1'b0, PARITY_EVEN, 1'b0, 1'b0);
    rd(OFS_RXDATA, 32'h050);
    tx.send(9'h066, 1'b0, PARITY_EVEN, 1'b0, 1'b0);
    rd(OFS_RXDATA, 32'h051);
    rd(OFS_RXDATA, 32'h052);
    rd(OFS_RXDATA, 32'h053);
    rd(OFS_STATUS, 32'h12);
    wr(OFS_STATUS, 32'h00);
    rd(OFS_STATUS, 32'h10);
    done("overrun");
    wr(OFS_STATUS, 32'h20);
    tx.send(9'h0a5, 1'b0, PARITY_EVEN, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h31);
    rd(OFS_RXDATA, 32'h0a5);
    wr(OFS_CONTROL, 32'h3);
    apb(1'b0, OFS_INTSTAT, 32'h0);
    tx.send(9'h0a5, 1'b1, PARITY_NONE, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h30);
    tx.send(9'h1a5, 1'b1, PARITY_NONE, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h31);
    rd(OFS_RXDATA, 32'h1a5);
    rd(OFS_INTSTAT, 32'h11);
    done("address");
    print_verdict();
  end
endmodule // urs_rx_status_tb

bind urs_rx_status urs_rx_status_assertions chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxPin(rxPin), .irq(irq));
